/* File: rtl/dcs_core.sv */
// Purpose: Synthesis core: phase accumulator, cosine amplitude, dividers
// Assumes: Clock inputs are sampled levels synchronous to sys_clk
// Notes: The sample clock is modelled as a strobe of selected input edges
//
// Contract
// [RULE_01] 48-bit accumulator adds step each sample
// [RULE_02] Output rate is step times rate over 2^48
// [RULE_03] Phase offset added before amplitude conversion
// [RULE_04] Amplitude follows cosine of one revolution
// [RULE_05] One 10-bit amplitude word per sample
// [RULE_06] 14-bit programmable rising edge delay
// [RULE_07] RF divider ratio 1, 2, 4, 8 or bypassed
// [RULE_08] Sample clock from divided or undivided RF
// [RULE_09] Software engages RF divider above 400 MHz
// [RULE_10] Reference and feedback divided by 1 to 16
// [RULE_11] Software divides inputs above 200 MHz
// [RULE_12] Charge pump scale 1 to 8 from field
// [RULE_13] Driver source: RF, RF divided, or feedback
// [RULE_14] Bit selects internal driver current resistor
// [RULE_15] Surge current extra rise, fall, default off
// [RULE_16] Bit engages reference crystal oscillator
// [RULE_17] Eight profiles chosen by select pins
// [RULE_18] Accumulator wraps modulo 2^48, no flag
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dcs_core (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic rf_clock_input,
	input wire logic feedback_clock_input,
	input wire logic reference_clock_input,
	input wire logic [2:0] profile_select_pins,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [dcs_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic [dcs_pkg::AMP_W-1:0] dac_amp_word,
	output logic dac_amp_valid,
	output logic drv_clk_out,
	output logic ref_div_out,
	output logic fb_div_out,
	output logic [3:0] cp_scale_mult,
	output logic drv_int_rset_en,
	output logic drv_rise_surge_en,
	output logic drv_fall_surge_en,
	output logic drv_def_surge_off,
	output logic ref_xtal_osc_en
);
	import dcs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = data[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Edge counter shared by all three dividers; count holds edges seen
	function automatic logic [DIV_W-1:0] div_next(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] last,
			input logic edge_in);
		logic [DIV_W-1:0] res;
		res = cnt;
		if (edge_in) begin
			res = (cnt == last) ? '0 : cnt + 4'h1;
		end
		return res;
	endfunction

	// Parabolic cosine: cheap, no table, peak error near six percent
	function automatic logic [AMP_W-1:0] cos_amp(input logic [11:0] ph);
		logic [11:0] q;
		logic [10:0] s;
		logic [22:0] prod;
		logic [8:0] mag;
		q = ph + 12'h400;
		s = q[10:0];
		prod = 23'(s) * (23'h800 - 23'(s));
		mag = (prod[22:11] > 12'h1ff) ? 9'h1ff : prod[19:11];
		return q[11] ? (AMP_MID - 10'(mag)) : (AMP_MID + 10'(mag));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic [ADDR_W-1:0] awaddr_ff, araddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_got_ff, w_got_ff;
	logic wr_go;
	logic [31:0] rd_mux;
	logic rd_hit, wr_hit;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [SCW_W-1:0] scw_ff;
	logic [31:0] step_lo_ff;
	logic [15:0] step_hi_ff;
	logic [DLY_W-1:0] dly_ff;
	logic [ACC_W-1:0] acc_ff;
	logic [AMP_W-1:0] amp_ff;

	assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign wr_hit = (awaddr_ff[7:2] <= REG_COMMIT[7:2]) && (awaddr_ff[1:0] == 2'h0);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
				w_got_ff <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = '0;
		case (araddr_ff)
			REG_CTRL: rd_mux = 32'(ctrl_ff);
			REG_SCW: rd_mux = 32'(scw_ff);
			REG_STEP_LO: rd_mux = step_lo_ff;
			REG_STEP_HI: rd_mux = 32'(step_hi_ff);
			REG_DELAY: rd_mux = 32'(dly_ff);
			REG_COMMIT: rd_mux = '0;
			REG_STATUS: rd_mux = {29'h0, profile_select_pins};
			REG_PHASE: rd_mux = acc_ff[47:16];
			REG_AMP: rd_mux = 32'(amp_ff);
			default: rd_hit = 1'b0;
		endcase
	end

	// Read answers one cycle after the address is held, from a stable latch
	logic ar_got_ff;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			araddr_ff <= '0;
			ar_got_ff <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				araddr_ff <= s_axi_araddr;
				s_axi_arready <= 1'b0;
				ar_got_ff <= 1'b1;
			end
			if (ar_got_ff) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
				ar_got_ff <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic [31:0] ctrl_wr, scw_wr;
	logic commit_go;
	assign ctrl_wr = merge_strb(32'(ctrl_ff), wdata_ff, wstrb_ff);
	assign scw_wr = merge_strb(32'(scw_ff), wdata_ff, wstrb_ff);
	assign commit_go = wr_go && (awaddr_ff == REG_COMMIT) && wstrb_ff[0];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_ff <= CTRL_RST;
			scw_ff <= SCW_RST;
			step_lo_ff <= '0;
			step_hi_ff <= '0;
			dly_ff <= '0;
			cp_scale_mult <= 4'h1;
		end else if (clk_en && wr_go) begin
			case (awaddr_ff)
				REG_CTRL: ctrl_ff <= ctrl_wr[CTRL_W-1:0];
				REG_SCW: begin
					scw_ff <= scw_wr[SCW_W-1:0];
					cp_scale_mult <= {1'b0, scw_wr[SCW_CP_LSB +: 3]} + 4'h1; // see [RULE_12]
				end
				REG_STEP_LO: step_lo_ff <= merge_strb(step_lo_ff, wdata_ff, wstrb_ff);
				// Upper half of the step word register is not stored
				REG_STEP_HI: step_hi_ff <= 16'(merge_strb(32'(step_hi_ff), wdata_ff, wstrb_ff));
				REG_DELAY: dly_ff <= DLY_W'(merge_strb(32'(dly_ff), wdata_ff, wstrb_ff)); // see [RULE_06]
				default: ;
			endcase
		end
	end

	assign drv_int_rset_en = ctrl_ff[CTL_INT_RSET]; // see [RULE_14]
	assign drv_rise_surge_en = ctrl_ff[CTL_RISE_SURGE]; // see [RULE_15]
	assign drv_fall_surge_en = ctrl_ff[CTL_FALL_SURGE]; // see [RULE_15]
	assign drv_def_surge_off = ctrl_ff[CTL_NO_DEF_SURGE]; // see [RULE_15]
	assign ref_xtal_osc_en = ctrl_ff[CTL_XTAL]; // see [RULE_16]

	////////////////////////////////////////////////////////////////////////
	// Profiles: step and delay staged by software, committed to an entry
	logic [PROF_W-1:0] prof_rd;
	logic [ACC_W-1:0] act_step;
	logic [DLY_W-1:0] act_dly;

	dcs_prof_mem u_prof_mem (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.wr_en(commit_go),
		.wr_idx(wdata_ff[2:0]),
		.wr_data({dly_ff, step_hi_ff, step_lo_ff}),
		.rd_idx(profile_select_pins), // see [RULE_17]
		.rd_data_ff(prof_rd)
	);
	assign act_step = prof_rd[ACC_W-1:0];
	assign act_dly = prof_rd[PROF_W-1:ACC_W];

	////////////////////////////////////////////////////////////////////////
	// Input edges and dividers
	logic rf_prev_ff, fb_prev_ff, ref_prev_ff;
	logic rf_rise, fb_rise, ref_rise;
	logic [DIV_W-1:0] rf_cnt_ff, ref_cnt_ff, fb_cnt_ff;
	logic [DIV_W-1:0] rf_last;
	logic div_stb, sample_stb;

	assign rf_rise = rf_clock_input && !rf_prev_ff;
	assign fb_rise = feedback_clock_input && !fb_prev_ff;
	assign ref_rise = reference_clock_input && !ref_prev_ff;
	// Ratio code 0..3 gives 1, 2, 4, 8; bypass forces ratio one
	assign rf_last = ctrl_ff[CTL_BYPASS] ? 4'h0 : (4'h1 << ctrl_ff[CTL_RDIV_LSB +: 2]) - 4'h1; // see [RULE_07]
	assign div_stb = rf_rise && (rf_cnt_ff >= rf_last);
	assign sample_stb = ctrl_ff[CTL_SCLK_DIV] ? div_stb : rf_rise; // see [RULE_08]

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rf_prev_ff <= 1'b0;
			fb_prev_ff <= 1'b0;
			ref_prev_ff <= 1'b0;
			rf_cnt_ff <= '0;
			ref_cnt_ff <= '0;
			fb_cnt_ff <= '0;
			ref_div_out <= 1'b0;
			fb_div_out <= 1'b0;
		end else if (clk_en) begin
			rf_prev_ff <= rf_clock_input;
			fb_prev_ff <= feedback_clock_input;
			ref_prev_ff <= reference_clock_input;
			// A shrunk ratio wraps at once rather than counting past it
			rf_cnt_ff <= div_stb ? 4'h0 : div_next(rf_cnt_ff, 4'hf, rf_rise); // see [RULE_07]
			ref_cnt_ff <= div_next(ref_cnt_ff, scw_ff[SCW_REF_LSB +: DIV_W], ref_rise); // see [RULE_10]
			fb_cnt_ff <= div_next(fb_cnt_ff, scw_ff[SCW_FB_LSB +: DIV_W], fb_rise); // see [RULE_10]
			ref_div_out <= ref_rise && (ref_cnt_ff == scw_ff[SCW_REF_LSB +: DIV_W]);
			fb_div_out <= fb_rise && (fb_cnt_ff == scw_ff[SCW_FB_LSB +: DIV_W]);
		end
	end

	// Driver source mux; the path not feeding the sample clock is free here
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			drv_clk_out <= 1'b0;
		end else if (clk_en) begin
			case (ctrl_ff[CTL_DRV_LSB +: 2]) // see [RULE_13]
				DRV_SRC_DIV: drv_clk_out <= div_stb;
				DRV_SRC_FB: drv_clk_out <= feedback_clock_input;
				default: drv_clk_out <= rf_clock_input;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Phase accumulator and amplitude
	logic [DLY_W-1:0] phase_idx;
	// Delay word shifts the top phase bits, giving the edge delay
	assign phase_idx = acc_ff[ACC_W-1 -: DLY_W] + act_dly; // see [RULE_03]

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc_ff <= '0;
		end else if (clk_en && sample_stb) begin
			acc_ff <= acc_ff + act_step; // see [RULE_01] see [RULE_02] see [RULE_18]
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			amp_ff <= AMP_MID;
			dac_amp_valid <= 1'b0;
		end else if (clk_en) begin
			dac_amp_valid <= sample_stb; // see [RULE_05]
			if (sample_stb) begin
				amp_ff <= cos_amp(phase_idx[DLY_W-1 -: 12]); // see [RULE_04]
			end
		end
	end
	assign dac_amp_word = amp_ff;

	////////////////////////////////////////////////////////////////////////
	acc_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_01]
		clk_en && sample_stb |=> acc_ff == $past(acc_ff) + $past(act_step))
		else $error("accumulator did not add step");
	acc_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_18]
		(clk_en && !sample_stb) || !clk_en |=> acc_ff == $past(acc_ff))
		else $error("accumulator moved without sample");
	amp_strobe_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_05]
		clk_en && sample_stb |=> dac_amp_valid)
		else $error("amplitude word missing");
	amp_peak_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_04]
		clk_en && sample_stb && phase_idx == '0 |=> dac_amp_word == AMP_MAX)
		else $error("cosine peak wrong at zero phase");
	div_bypass_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_07]
		ctrl_ff[CTL_BYPASS] |-> div_stb == rf_rise)
		else $error("bypassed divider dropped an edge");
	ref_div_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_10]
		clk_en && ref_rise && ref_cnt_ff == scw_ff[SCW_REF_LSB +: DIV_W] |=> ref_div_out ##1 !ref_div_out || ref_rise)
		else $error("reference divider output wrong");
	drv_src_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_13]
		clk_en && ctrl_ff[CTL_DRV_LSB +: 2] == DRV_SRC_FB |=> drv_clk_out == $past(feedback_clock_input))
		else $error("driver source not feedback");
	cp_mult_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // see [RULE_12]
		cp_scale_mult == {1'b0, scw_ff[SCW_CP_LSB +: 3]} + 4'h1)
		else $error("charge pump scale mismatch");
	acc_wrap_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		clk_en && sample_stb && acc_ff[ACC_W-1] ##1 !acc_ff[ACC_W-1]);
	prof_swap_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		profile_select_pins != $past(profile_select_pins) && clk_en);
	div_sample_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		ctrl_ff[CTL_SCLK_DIV] && rf_last == 4'h7 && sample_stb);
endmodule
`default_nettype wire

/* File: rtl/dcs_pkg.sv */
// Purpose: Shared constants for the clock synthesizer digital core
// Assumes: AXI4-Lite with 32-bit data and 8-bit byte addresses
// Notes: Control fields sit in software registers at the offsets below
package dcs_pkg;
	localparam int ADDR_W = 8;
	localparam int ACC_W = 48;
	localparam int DLY_W = 14;
	localparam int AMP_W = 10;
	localparam int PROF_N = 8;
	localparam int PROF_W = ACC_W + DLY_W;
	localparam int DIV_W = 4;
	localparam int CTRL_W = 11;
	localparam int SCW_W = 12;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SCW = 8'h04;
	localparam logic [7:0] REG_STEP_LO = 8'h08;
	localparam logic [7:0] REG_STEP_HI = 8'h0c;
	localparam logic [7:0] REG_DELAY = 8'h10;
	localparam logic [7:0] REG_COMMIT = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_PHASE = 8'h1c;
	localparam logic [7:0] REG_AMP = 8'h20;

	// Control register fields
	localparam int CTL_BYPASS = 0;
	localparam int CTL_RDIV_LSB = 1;
	localparam int CTL_SCLK_DIV = 3;
	localparam int CTL_DRV_LSB = 4;
	localparam int CTL_INT_RSET = 6;
	localparam int CTL_RISE_SURGE = 7;
	localparam int CTL_FALL_SURGE = 8;
	localparam int CTL_NO_DEF_SURGE = 9;
	localparam int CTL_XTAL = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

	// Second control word fields: divider fields hold ratio minus one
	localparam int SCW_CP_LSB = 0;
	localparam int SCW_REF_LSB = 4;
	localparam int SCW_FB_LSB = 8;
	localparam logic [SCW_W-1:0] SCW_RST = 12'h000;

	// Driver source codes
	localparam logic [1:0] DRV_SRC_RF = 2'h0;
	localparam logic [1:0] DRV_SRC_DIV = 2'h1;
	localparam logic [1:0] DRV_SRC_FB = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [AMP_W-1:0] AMP_MID = 10'h200;
	localparam logic [AMP_W-1:0] AMP_MAX = 10'h3ff;
endpackage

/* File: rtl/dcs_prof_mem.sv */
// Purpose: Eight-entry profile store, step word and delay word per entry
// Assumes: One write port from software, one read port from the select pins
// Notes: Read data are registered, so a new selection shows one cycle later
`timescale 1ns/1ps
`default_nettype none
module dcs_prof_mem (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [dcs_pkg::PROF_W-1:0] wr_data,
	input wire logic [2:0] rd_idx,
	output logic [dcs_pkg::PROF_W-1:0] rd_data_ff
);
	import dcs_pkg::*;

	logic [PROF_W-1:0] mem_ff [PROF_N];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < PROF_N; i++) begin
				mem_ff[i] <= '0;
			end
		end else if (clk_en && wr_en) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_ff <= '0;
		end else if (clk_en) begin
			rd_data_ff <= mem_ff[rd_idx];
		end
	end
endmodule
`default_nettype wire

/* File: verif/dcs_dac_model.sv */
// Purpose: Converter-side sink for the amplitude word stream
// Assumes: One valid pulse per amplitude word
// Notes: Counts the words taken and holds the last one
`timescale 1ns/1ps
`default_nettype none
module dcs_dac_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic amp_valid,
	input wire logic [dcs_pkg::AMP_W-1:0] amp_word,
	output int n_samp_ff,
	output logic [dcs_pkg::AMP_W-1:0] last_word_ff
);
	import dcs_pkg::*;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			n_samp_ff <= 0;
			last_word_ff <= AMP_MID;
		end else if (amp_valid) begin
			// Converter latches exactly one word per sample strobe
			n_samp_ff <= n_samp_ff + 1;
			last_word_ff <= amp_word;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the synthesis core
// Assumes: Input clocks are slow levels, low between edges
// Notes: Bus tasks judge handshakes at the rising edge and change signals right after it
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcs_pkg::*;
	logic sys_clk = 0;
	logic sys_rst = 1;
	logic clk_en = 1;
	logic rf_clock_input = 0;
	logic feedback_clock_input = 0;
	logic reference_clock_input = 0;
	logic [2:0] profile_select_pins = 3'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rd;
	logic [AMP_W-1:0] dac_amp_word, last_word_ff;
	logic dac_amp_valid, drv_clk_out, ref_div_out, fb_div_out, drv_int_rset_en;
	logic drv_rise_surge_en, drv_fall_surge_en, drv_def_surge_off, ref_xtal_osc_en;
	logic [3:0] cp_scale_mult;
	int n_samp_ff, ref_cnt_ff, fb_cnt_ff, n_fail = 0, check_count = 0, cyc = 0;

	always #50 sys_clk = ~sys_clk;

	dcs_core dut_u (.sys_clk, .sys_rst, .clk_en, .rf_clock_input, .feedback_clock_input,
		.reference_clock_input, .profile_select_pins, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .dac_amp_word, .dac_amp_valid, .drv_clk_out, .ref_div_out,
		.fb_div_out, .cp_scale_mult, .drv_int_rset_en, .drv_rise_surge_en, .drv_fall_surge_en,
		.drv_def_surge_off, .ref_xtal_osc_en);
	dcs_dac_model dac_u (.sys_clk, .sys_rst, .amp_valid(dac_amp_valid), .amp_word(dac_amp_word),
		.n_samp_ff, .last_word_ff);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ref_cnt_ff <= 0;
			fb_cnt_ff <= 0;
		end else begin
			ref_cnt_ff <= ref_cnt_ff + int'(ref_div_out);
			fb_cnt_ff <= fb_cnt_ff + int'(fb_div_out);
		end
	end

	// Whole run needs about five hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (n_fail == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	// Values read right after the edge are those the edge sampled
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic done;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		done = 0;
		while (!done) begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				rsp = s_axi_bresp;
				done = 1;
			end
		end
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic axr(input logic [7:0] a);
		logic done;
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		done = 0;
		while (!done) begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				done = 1;
			end
		end
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	// All three inputs pulse together, low for a cycle between edges
	task automatic edges(input int n);
		repeat (n) begin
			rf_clock_input <= 1'b1;
			feedback_clock_input <= 1'b1;
			reference_clock_input <= 1'b1;
			@(posedge sys_clk);
			rf_clock_input <= 1'b0;
			feedback_clock_input <= 1'b0;
			reference_clock_input <= 1'b0;
			@(posedge sys_clk);
		end
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic set_prof(input logic [2:0] idx, input logic [47:0] step, input logic [13:0] dly);
		axw(REG_STEP_LO, step[31:0]);
		axw(REG_STEP_HI, {16'h0, step[47:32]});
		axw(REG_DELAY, {18'h0, dly});
		axw(REG_COMMIT, {29'h0, idx});
		profile_select_pins <= idx;
		repeat (2) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk("cp_scale_mult", 4'h1, cp_scale_mult);
		chk("dac_amp_word", AMP_MID, dac_amp_word);
		chk("drv_levels", 5'h00, {drv_int_rset_en, drv_rise_surge_en, drv_fall_surge_en,
			drv_def_surge_off, ref_xtal_osc_en});
	endtask

	// Quarter-turn step: amplitude walks peak, mid, trough, mid and wraps
	task automatic t_accum();
		logic [AMP_W-1:0] exp_amp [4];
		int base;
		exp_amp = '{10'h3ff, 10'h200, 10'h001, 10'h200};
		set_prof(3'h1, 48'h4000_0000_0000, 14'h0000);
		base = n_samp_ff;
		for (int i = 0; i < 4; i++) begin
			edges(1);
			chk("amp", exp_amp[i], last_word_ff);
			if (i == 0) begin
				axr(REG_PHASE);
				chk("phase", 32'h4000_0000, rd);
			end
		end
		chk("samples", 4, n_samp_ff - base);
		axr(REG_PHASE);
		chk("wrap", 32'h0, rd);
	endtask

	task automatic t_offset();
		set_prof(3'h2, 48'h0, 14'h2000);
		edges(1);
		chk("offset_amp", 10'h001, last_word_ff);
		axr(REG_STATUS);
		chk("status", 32'h2, rd);
	endtask

	task automatic t_levels();
		axw(REG_CTRL, 32'h7c0);
		chk("bresp", RESP_OKAY, rsp);
		chk("drv_levels", 5'h1f, {drv_int_rset_en, drv_rise_surge_en, drv_fall_surge_en,
			drv_def_surge_off, ref_xtal_osc_en});
		axr(REG_CTRL);
		chk("ctrl", 32'h7c0, rd);
		axw(REG_CTRL, 32'h0);
	endtask

	// Sample strobes per 8 edges for ratios 1, 2, 4, 8, then bypass
	task automatic t_rdiv();
		int base;
		for (int i = 0; i < 5; i++) begin
			axw(REG_CTRL, (i < 4) ? (32'h8 | (i << 1)) : 32'hf);
			base = n_samp_ff;
			edges(8);
			chk("rdiv_samples", (i < 4) ? (8 >> i) : 8, n_samp_ff - base);
		end
		axw(REG_CTRL, 32'h0);
	endtask

	task automatic t_mn(input logic [11:0] scw, input logic [3:0] cp, input int rexp, input int fexp);
		int rb, fb;
		axw(REG_SCW, {20'h0, scw});
		rb = ref_cnt_ff;
		fb = fb_cnt_ff;
		edges(48);
		chk("cp_scale_mult", cp, cp_scale_mult);
		chk("ref_pulses", rexp, ref_cnt_ff - rb);
		chk("fb_pulses", fexp, fb_cnt_ff - fb);
	endtask

	task automatic t_drv();
		axw(REG_CTRL, 32'h20);
		feedback_clock_input <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("drv_fb_hi", 1'b1, drv_clk_out);
		feedback_clock_input <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("drv_fb_lo", 1'b0, drv_clk_out);
		axw(REG_CTRL, 32'h0);
		feedback_clock_input <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("drv_rf_lo", 1'b0, drv_clk_out);
		feedback_clock_input <= 1'b0;
		edges(1);
		// Divided source at ratio one: one pulse per RF edge
		axw(REG_CTRL, 32'h10);
		rf_clock_input <= 1'b1;
		@(posedge sys_clk);
		rf_clock_input <= 1'b0;
		@(posedge sys_clk);
		chk("drv_div_hi", 1'b1, drv_clk_out);
		@(posedge sys_clk);
		chk("drv_div_lo", 1'b0, drv_clk_out);
		axw(REG_CTRL, 32'h0);
	endtask

	task automatic t_err();
		axr(8'h24);
		chk("rresp", RESP_SLVERR, rsp);
		chk("rdata", 32'h0, rd);
		axw(8'h24, 32'hffff_ffff);
		chk("bresp", RESP_SLVERR, rsp);
		axr(REG_COMMIT);
		chk("commit_rd", 32'h0, rd);
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_accum();
		t_offset();
		t_levels();
		t_rdiv();
		t_mn(12'hf27, 4'h8, 16, 3);
		t_mn(12'h0f0, 4'h1, 3, 48);
		t_drv();
		t_err();
		end_sim();
	end
endmodule
`default_nettype wire
